// ### pkg/transient_capture_cfg.svh
// Constants for the transient capture trigger block: offsets, fields, resets.
`ifndef TRANSIENT_CAPTURE_CFG_SVH
`define TRANSIENT_CAPTURE_CFG_SVH

// ==========================================
// Register indices (byte address is four times the index)
`define TC_IDX_TRIGGER_DELAY 12'h00c
`define TC_IDX_TRIGGER_THRESHOLD 12'h00e
`define TC_IDX_OPTIONS 12'h010
`define TC_IDX_CONTROL 12'h020
`define TC_IDX_STATUS 12'h021

// ==========================================
// Field positions of the options register
`define TC_OPT_CHAN_LSB 12
`define TC_OPT_CHAN_MSB 15
`define TC_OPT_SLOPE_BIT 10
`define TC_OPT_POS_LSB 8
`define TC_OPT_POS_MSB 9
`define TC_OPT_SIZE_LSB 0
`define TC_OPT_SIZE_MSB 4

// ==========================================
// Field positions of the control register
`define TC_CTL_START_BIT 0
`define TC_CTL_ABORT_BIT 1
`define TC_CTL_SRC_LSB 4
`define TC_CTL_SRC_MSB 5

// ==========================================
// Reset values
`define TC_RST_TRIGGER_DELAY 16'h0000
`define TC_RST_TRIGGER_THRESHOLD 16'h0000
`define TC_RST_OPTIONS 16'h0017
`define TC_RST_SOURCE 2'h0

`endif

// ### pkg/transient_capture_pkg.sv
// Types shared by the transient capture trigger block.
`default_nettype none
package transient_capture_pkg;

  // ==========================================
  // Capture sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,  // Not capturing
    ST_ARMED = 2'h1,  // Storing, waiting for a trigger
    ST_DELAY = 2'h3,  // Trigger seen, counting delay samples
    ST_POST  = 2'h2   // Collecting samples after the trigger
  } cap_state_t;

  // Trigger source codes
  typedef enum logic [1:0] {
    SRC_EXT     = 2'h0,  // External trigger, rising
    SRC_EXT_INV = 2'h1,  // External trigger, falling
    SRC_IO      = 2'h2,  // I/O trigger
    SRC_DSP     = 2'h3   // Threshold comparison
  } trig_src_t;

  // Trigger placement codes
  typedef enum logic [1:0] {
    POS_PRE      = 2'h0,  // Data before the trigger
    POS_MID      = 2'h1,  // Trigger centred
    POS_POST     = 2'h2,  // Data after the trigger
    POS_PRE_ALT  = 2'h3   // Treated as pre
  } trig_pos_t;

  // Options register contents
  typedef struct packed {
    logic [3:0] chan_sel;   // Monitored channel
    logic slope;            // 1 above, 0 below
    trig_pos_t pos;         // Trigger placement
    logic [4:0] buf_size;   // Buffer size code
  } cap_opts_t;

  // Trigger pins sampled by the block
  typedef struct packed {
    logic ext;  // External trigger level
    logic io;   // I/O trigger level
  } trig_pins_t;

endpackage
`default_nettype wire

// ### hw/dsp_threshold_compare.sv
// Signed threshold comparison on one selected input channel.
`default_nettype none
module dsp_threshold_compare #(
  parameter int CHANNELS = 16,
  parameter int SAMPLE_W = 16
) (
  input wire logic pclk,                                 // System clock
  input wire logic presetn,                              // Async reset, active low
  input wire logic sample_tick,                          // One pulse per sample event
  input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] samples, // All channel samples
  input wire logic [3:0] chan_sel,                       // Channel to watch
  input wire logic slope,                                // 1 above, 0 below
  input wire logic [SAMPLE_W-1:0] threshold,             // Two's complement level
  output logic hit                                       // Pulse, one cycle after tick
);

  logic signed [SAMPLE_W-1:0] chosen;  // Selected channel sample
  logic signed [SAMPLE_W-1:0] level;   // Threshold as signed

  // ==========================================
  // Channel select and compare
  always_comb begin
    chosen = $signed(samples[chan_sel]);
    level = $signed(threshold);
  end

  // Evaluate on every sample event; registered so it costs one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit <= 1'b0;
    end else if (sample_tick) begin
      hit <= slope ? (chosen > level) : (chosen < level);
    end else begin
      hit <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### hw/transient_capture_trigger.sv
// Transient capture trigger qualification with its APB register file.
`include "transient_capture_cfg.svh"
`default_nettype none
module transient_capture_trigger #(
  parameter int CHANNELS = 16,                       // Input channels
  parameter int SAMPLE_W = 16,                       // Sample width
  parameter logic [15:0] OPTIONS_RESET = `TC_RST_OPTIONS  // Options reset value
) (
  input wire logic pclk,                                  // 40 MHz clock
  input wire logic presetn,                               // Async reset, active low
  input wire logic psel,                                  // APB select
  input wire logic penable,                               // APB enable
  input wire logic pwrite,                                // APB direction
  input wire logic [11:0] paddr,                          // APB byte address
  input wire logic [31:0] pwdata,                         // APB write data
  output logic [31:0] prdata,                             // APB read data
  output logic pready,                                    // APB ready
  output logic pslverr,                                   // APB error
  input wire logic sample_tick,                           // Sample clock event pulse
  input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] samples,  // Current samples
  input wire transient_capture_pkg::trig_pins_t trig_pins, // Trigger inputs
  output logic capture_active_r,                          // Capture mode running
  output logic store_en_r,                                // Store this sample
  output logic trig_seen_r,                               // Pulse: trigger recognised
  output logic trig_fire_r,                               // Pulse: trigger after delay
  output logic capture_done_r,                            // Pulse: capture finished
  output transient_capture_pkg::cap_opts_t opts_r         // Options for buffer logic
);

  // ==========================================
  // Registers and state
  logic [15:0] trigger_delay_r;               // Samples of delay
  logic [15:0] trigger_threshold_r;           // Signed threshold
  transient_capture_pkg::trig_src_t src_r;    // Trigger source
  transient_capture_pkg::cap_state_t state_r; // Sequencer state
  logic [15:0] delay_cnt_r;                   // Delay samples counted
  logic [31:0] post_cnt_r;                    // Post samples counted
  logic [31:0] post_target;                   // Samples wanted after trigger
  logic [31:0] buf_len;                       // Buffer length in samples
  logic trig_sticky_r;                        // Trigger seen this capture
  logic ext_d_r;                              // Previous external level
  logic io_d_r;                               // Previous I/O level
  logic dsp_hit;                              // Comparator pulse
  logic trig_event;                           // Trigger from chosen source
  logic fire;                                 // Delay expired this cycle
  logic wr_en;                                // APB write takes effect
  logic rd_setup;                             // APB setup of a read or write
  logic [11:0] idx;                           // Register index
  logic start_req;                            // Start written
  logic abort_req;                            // Abort written

  // ==========================================
  // APB decode
  always_comb begin
    idx = {2'h0, paddr[11:2]};
    wr_en = psel && penable && pwrite && pready;
    rd_setup = psel && !penable;
    start_req = wr_en && (idx == `TC_IDX_CONTROL) && pwdata[`TC_CTL_START_BIT];
    abort_req = wr_en && (idx == `TC_IDX_CONTROL) && pwdata[`TC_CTL_ABORT_BIT];
  end

  // Zero wait slave: ready stands high, in reset as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b1;
    end
  end

  // Read data and error are loaded in the setup cycle so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= 1'b0;
      case (idx)
        `TC_IDX_TRIGGER_DELAY: prdata <= {16'h0000, trigger_delay_r};
        `TC_IDX_TRIGGER_THRESHOLD: prdata <= {16'h0000, trigger_threshold_r};
        `TC_IDX_OPTIONS: begin
          // Reserved bits 11 and 7..5 read as zero
          prdata <= {16'h0000, opts_r.chan_sel, 1'b0, opts_r.slope, opts_r.pos, 3'h0, opts_r.buf_size};
        end
        `TC_IDX_CONTROL: prdata <= {26'h0, src_r, 4'h0};
        `TC_IDX_STATUS: prdata <= {28'h0, trig_sticky_r, capture_active_r, state_r};
        default: begin
          // Unmapped: read zero, flag error
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_delay_r <= `TC_RST_TRIGGER_DELAY;
    end else if (wr_en && idx == `TC_IDX_TRIGGER_DELAY) begin
      trigger_delay_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_threshold_r <= `TC_RST_TRIGGER_THRESHOLD;
    end else if (wr_en && idx == `TC_IDX_TRIGGER_THRESHOLD) begin
      trigger_threshold_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opts_r <= transient_capture_pkg::cap_opts_t'({OPTIONS_RESET[15:12], OPTIONS_RESET[10:8],
                                                    OPTIONS_RESET[4:0]});
    end else if (wr_en && idx == `TC_IDX_OPTIONS) begin
      opts_r.chan_sel <= pwdata[`TC_OPT_CHAN_MSB:`TC_OPT_CHAN_LSB];
      opts_r.slope <= pwdata[`TC_OPT_SLOPE_BIT];
      opts_r.pos <= transient_capture_pkg::trig_pos_t'(pwdata[`TC_OPT_POS_MSB:`TC_OPT_POS_LSB]);
      opts_r.buf_size <= pwdata[`TC_OPT_SIZE_MSB:`TC_OPT_SIZE_LSB];
    end
  end

  // Source select is only taken while idle so a capture never changes source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= transient_capture_pkg::trig_src_t'(`TC_RST_SOURCE);
    end else if (wr_en && idx == `TC_IDX_CONTROL && state_r == transient_capture_pkg::ST_IDLE) begin
      src_r <= transient_capture_pkg::trig_src_t'(pwdata[`TC_CTL_SRC_MSB:`TC_CTL_SRC_LSB]);
    end
  end

  // ==========================================
  // Trigger sources
  dsp_threshold_compare #(
    .CHANNELS(CHANNELS),
    .SAMPLE_W(SAMPLE_W)
  ) u_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .sample_tick(sample_tick),
    .samples(samples),
    .chan_sel(opts_r.chan_sel),
    .slope(opts_r.slope),
    .threshold(trigger_threshold_r),
    .hit(dsp_hit)
  );

  // Edge history of the pin triggers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d_r <= 1'b0;
      io_d_r <= 1'b0;
    end else begin
      ext_d_r <= trig_pins.ext;
      io_d_r <= trig_pins.io;
    end
  end

  // Pick the event of the selected source
  always_comb begin
    case (src_r)
      transient_capture_pkg::SRC_EXT: trig_event = trig_pins.ext && !ext_d_r;
      transient_capture_pkg::SRC_EXT_INV: trig_event = !trig_pins.ext && ext_d_r;
      transient_capture_pkg::SRC_IO: trig_event = trig_pins.io && !io_d_r;
      transient_capture_pkg::SRC_DSP: trig_event = dsp_hit;
      default: trig_event = 1'b0;
    endcase
  end

  // ==========================================
  // Placement: how many samples follow the trigger
  always_comb begin
    buf_len = 32'h0000_0001 << opts_r.buf_size;
    case (opts_r.pos)
      transient_capture_pkg::POS_POST: post_target = buf_len;
      transient_capture_pkg::POS_MID: post_target = buf_len >> 1;
      default: post_target = 32'h0000_0000;
    endcase
  end

  // Delay expires on the sample event that reaches the programmed count
  always_comb begin
    fire = (state_r == transient_capture_pkg::ST_DELAY) && sample_tick &&
           (delay_cnt_r + 16'h0001 == trigger_delay_r);
  end

  // ==========================================
  // Capture sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= transient_capture_pkg::ST_IDLE;
      delay_cnt_r <= 16'h0000;
      post_cnt_r <= 32'h0000_0000;
      trig_fire_r <= 1'b0;
      capture_done_r <= 1'b0;
    end else begin
      trig_fire_r <= 1'b0;
      capture_done_r <= 1'b0;
      if (abort_req) begin
        // Abort drops back to idle without a done pulse
        state_r <= transient_capture_pkg::ST_IDLE;
      end else begin
        case (state_r)
          transient_capture_pkg::ST_IDLE: begin
            if (start_req) begin
              state_r <= transient_capture_pkg::ST_ARMED;
            end
          end
          transient_capture_pkg::ST_ARMED: begin
            delay_cnt_r <= 16'h0000;
            post_cnt_r <= 32'h0000_0000;
            if (trig_event) begin
              if (trigger_delay_r == 16'h0000) begin
                // No delay: trigger acts in the same cycle it is seen
                trig_fire_r <= 1'b1;
                if (post_target == 32'h0000_0000) begin
                  capture_done_r <= 1'b1;
                  state_r <= transient_capture_pkg::ST_IDLE;
                end else begin
                  state_r <= transient_capture_pkg::ST_POST;
                end
              end else begin
                state_r <= transient_capture_pkg::ST_DELAY;
              end
            end
          end
          transient_capture_pkg::ST_DELAY: begin
            if (fire) begin
              trig_fire_r <= 1'b1;
              if (post_target == 32'h0000_0000) begin
                capture_done_r <= 1'b1;
                state_r <= transient_capture_pkg::ST_IDLE;
              end else begin
                state_r <= transient_capture_pkg::ST_POST;
              end
            end else if (sample_tick) begin
              delay_cnt_r <= delay_cnt_r + 16'h0001;
            end
          end
          transient_capture_pkg::ST_POST: begin
            if (sample_tick) begin
              post_cnt_r <= post_cnt_r + 32'h0000_0001;
              if (post_cnt_r + 32'h0000_0001 == post_target) begin
                capture_done_r <= 1'b1;
                state_r <= transient_capture_pkg::ST_IDLE;
              end
            end
          end
          default: state_r <= transient_capture_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // Status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_seen_r <= 1'b0;
    end else begin
      trig_seen_r <= (state_r == transient_capture_pkg::ST_ARMED) && trig_event && !abort_req;
    end
  end

  // Sticky trigger flag; a new start clears it, an event in that cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sticky_r <= 1'b0;
    end else if ((state_r == transient_capture_pkg::ST_ARMED) && trig_event) begin
      trig_sticky_r <= 1'b1;
    end else if (start_req) begin
      trig_sticky_r <= 1'b0;
    end
  end

  // Every sample is stored while the capture runs; addressing lives downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_active_r <= 1'b0;
      store_en_r <= 1'b0;
    end else begin
      capture_active_r <= (state_r != transient_capture_pkg::ST_IDLE);
      store_en_r <= (state_r != transient_capture_pkg::ST_IDLE) && sample_tick;
    end
  end

endmodule
`default_nettype wire

// ### dv/tc_sample_source.sv
// Partner model: sample clock events and channel data feeding the trigger block.
`default_nettype none
module tc_sample_source #(
  parameter int CHANNELS = 16,
  parameter int SAMPLE_W = 16,
  parameter int PERIOD = 4
) (
  input wire logic pclk,                                 // Clock
  input wire logic presetn,                              // Reset, active low
  input wire logic [3:0] chan,                           // Channel carrying the level
  input wire logic [SAMPLE_W-1:0] level,                 // Level on the chosen channel
  output logic sample_tick,                              // One pulse per sample event
  output logic [CHANNELS-1:0][SAMPLE_W-1:0] samples      // All channel samples
);
  int cnt;  // Cycles since the last event
  // ==========================================
  // Event pacing and data
  // Other channels carry the inverted level with a moving pattern, so a wrong
  // channel choice shows up as a false or missing trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      sample_tick <= 1'b0;
      samples <= '0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sample_tick <= (cnt == 0);
      for (int i = 0; i < CHANNELS; i++) begin
        samples[i] <= (i == chan) ? level : ~level ^ SAMPLE_W'(cnt);
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/transient_capture_trigger_assertions.sv
// Port-level checker for the transient capture trigger block, with its bind.
`default_nettype none
`include "transient_capture_cfg.svh"
module tc_trigger_checker #(
  parameter int CHANNELS = 16,
  parameter int SAMPLE_W = 16
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic sample_tick, // Sample event
  input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] samples, // Samples
  input wire transient_capture_pkg::trig_pins_t trig_pins, // Trigger pins
  input wire logic capture_active_r, // Capture running
  input wire logic store_en_r, // Store strobe
  input wire logic trig_seen_r, // Trigger recognised
  input wire logic trig_fire_r, // Trigger after delay
  input wire logic capture_done_r, // Capture finished
  input wire transient_capture_pkg::cap_opts_t opts_r // Options
);
  logic [15:0] delay_r;     // Shadow of the programmed delay
  logic [16:0] tick_cnt_r;  // Sample events since recognition
  logic [31:0] wdata_r;     // Write data one cycle back
  // ==========================================
  // Helper state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_r <= 16'h0000;
      tick_cnt_r <= 17'h00000;
      wdata_r <= 32'h0;
    end else begin
      wdata_r <= pwdata;
      if (psel && penable && pwrite && paddr[11:2] == `TC_IDX_TRIGGER_DELAY) delay_r <= pwdata[15:0];
      if (trig_seen_r) tick_cnt_r <= {16'h0000, sample_tick};
      else if (sample_tick) tick_cnt_r <= tick_cnt_r + 17'h00001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Properties
  property p_ready; psel && penable |-> pready; endproperty
  property p_unmapped;
    psel && !penable && !(paddr[11:2] inside {`TC_IDX_TRIGGER_DELAY, `TC_IDX_TRIGGER_THRESHOLD,
      `TC_IDX_OPTIONS, `TC_IDX_CONTROL, `TC_IDX_STATUS}) |=> pslverr && prdata == 32'h0;
  endproperty
  property p_opts;
    psel && penable && pwrite && paddr[11:2] == `TC_IDX_OPTIONS
      |=> opts_r == {wdata_r[15:12], wdata_r[10:8], wdata_r[4:0]};
  endproperty
  property p_zero_dly; trig_seen_r && delay_r == 16'h0000 |-> trig_fire_r; endproperty
  property p_dly_cnt; trig_fire_r && delay_r != 16'h0000 |-> tick_cnt_r == {1'b0, delay_r}; endproperty
  property p_fire_active; trig_fire_r |-> capture_active_r; endproperty
  property p_pre_done;
    trig_fire_r && opts_r.pos inside {transient_capture_pkg::POS_PRE, transient_capture_pkg::POS_PRE_ALT}
      |-> capture_done_r;
  endproperty
  property p_post_len;
    trig_fire_r && opts_r.pos == transient_capture_pkg::POS_POST && opts_r.buf_size == 5'h00
      |-> !capture_done_r ##[1:8] capture_done_r;
  endproperty
  property p_done_idle; capture_done_r |-> ##2 !capture_active_r; endproperty
  property p_store; store_en_r |-> $past(sample_tick); endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_opts: assert property (p_opts) else $error("options not taken from write");
  a_zero_dly: assert property (p_zero_dly) else $error("zero delay did not fire at once");
  a_dly_cnt: assert property (p_dly_cnt) else $error("fire after wrong sample count");
  a_fire_active: assert property (p_fire_active) else $error("fire outside capture");
  a_pre_done: assert property (p_pre_done) else $error("pre placement not done at fire");
  a_post_len: assert property (p_post_len) else $error("post capture length wrong");
  a_done_idle: assert property (p_done_idle) else $error("no idle after done");
  a_store: assert property (p_store) else $error("store without sample event");
  c_mid: cover property (trig_fire_r && opts_r.pos == transient_capture_pkg::POS_MID);
  c_dly: cover property (trig_fire_r && delay_r != 16'h0000);
  c_err: cover property (psel && penable && pslverr);
endmodule
bind transient_capture_trigger tc_trigger_checker #(.CHANNELS(CHANNELS), .SAMPLE_W(SAMPLE_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
  .samples(samples), .trig_pins(trig_pins), .capture_active_r(capture_active_r), .store_en_r(store_en_r),
  .trig_seen_r(trig_seen_r), .trig_fire_r(trig_fire_r), .capture_done_r(capture_done_r), .opts_r(opts_r));
`default_nettype wire

// ### dv/transient_capture_trigger_tb.sv
// Self-checking testbench for the transient capture trigger block.
`default_nettype none
`include "transient_capture_cfg.svh"
module transient_capture_trigger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_DLY = `TC_IDX_TRIGGER_DELAY << 2;
  localparam logic [11:0] A_THR = `TC_IDX_TRIGGER_THRESHOLD << 2;
  localparam logic [11:0] A_OPT = `TC_IDX_OPTIONS << 2;
  localparam logic [11:0] A_CTL = `TC_IDX_CONTROL << 2;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sample_tick, capture_active_r, store_en_r, trig_seen_r, trig_fire_r, capture_done_r;
  logic [15:0][15:0] samples;
  transient_capture_pkg::trig_pins_t trig_pins = '0;
  transient_capture_pkg::cap_opts_t opts_r;
  logic [3:0] chan = 4'h0;    // Channel the partner drives with level
  logic [15:0] level = 16'h0000;
  int fail_count = 0, check_count = 0, cyc = 0, seen_n = 0;
  always #12.5 pclk = ~pclk;
  transient_capture_trigger uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(sample_tick), .samples(samples), .trig_pins(trig_pins), .capture_active_r(capture_active_r),
    .store_en_r(store_en_r), .trig_seen_r(trig_seen_r), .trig_fire_r(trig_fire_r),
    .capture_done_r(capture_done_r), .opts_r(opts_r));
  tc_sample_source u_src (.pclk(pclk), .presetn(presetn), .chan(chan), .level(level),
    .sample_tick(sample_tick), .samples(samples));
  // ==========================================
  // Recognition counter and hang guard
  always @(posedge pclk) begin
    if (trig_seen_r === 1'b1) seen_n++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ==========================================
  // APB master: request held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e_exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
    check({31'h0, e}, {31'h0, e_exp});
  endtask
  // Setup before start, the host's duty
  task prog(input logic [1:0] src, input logic [15:0] o, input logic [15:0] thr, input logic [15:0] d);
    wr(A_DLY, {16'h0, d});
    wr(A_THR, {16'h0, thr});
    wr(A_OPT, {16'h0, o});
    wr(A_CTL, {26'h0, src, 4'h0});
  endtask
  // Counts sample events from recognition to fire and from fire to done
  task run(input int d, input int nn);
    int ph, td, tn, k;
    ph = 0;
    td = 0;
    tn = 0;
    for (k = 0; k < 800 && ph < 3; k++) begin
      @(negedge pclk);
      if (ph == 0 && trig_seen_r === 1'b1) ph = 1;
      if (ph == 1) begin
        if (trig_fire_r === 1'b1) ph = 2;
        else if (sample_tick === 1'b1) td++;
      end else if (ph == 2) begin
        if (capture_done_r === 1'b1) ph = 3;
        else if (sample_tick === 1'b1) tn++;
      end
      if (ph == 2 && trig_fire_r === 1'b1 && capture_done_r === 1'b1) ph = 3;
    end
    check(ph, 3);
    check(td, d);
    check(tn, nn);
    repeat (3) @(negedge pclk);
    check({31'h0, capture_active_r}, 32'h0);
  endtask
  // ==========================================
  // Scenarios
  task t_regs();
    rd_chk(A_DLY, 32'h0, 1'b0);
    rd_chk(A_THR, 32'h0, 1'b0);
    rd_chk(A_OPT, {16'h0, `TC_RST_OPTIONS}, 1'b0);
    wr(A_DLY, 32'hffffffff);
    rd_chk(A_DLY, 32'h0000ffff, 1'b0);
    wr(A_THR, 32'hffff8000);
    rd_chk(A_THR, 32'h00008000, 1'b0);
    wr(A_OPT, 32'hffffffff);
    rd_chk(A_OPT, 32'h0000f71f, 1'b0);
    wr(12'h3fc, 32'h12345678);
    rd_chk(12'h3fc, 32'h0, 1'b1);
    $display("test registers done");
  endtask
  // Threshold trigger: no hit before start, none on a quiet level, then a hit
  task t_dsp(input logic slope, input logic [15:0] thr, input logic [15:0] quiet, input logic [15:0] hit,
             input logic [3:0] ch, input logic [1:0] pos, input logic [4:0] size, input logic [15:0] d, input int nn);
    int s0;
    chan <= ch;
    level <= hit;
    prog(2'h3, {ch, 1'b0, slope, pos, 3'h0, size}, thr, d);
    s0 = seen_n;
    repeat (30) @(posedge pclk);
    check(seen_n, s0);
    level <= quiet;
    repeat (8) @(posedge pclk);
    wr(A_CTL, 32'h00000031);
    repeat (30) @(posedge pclk);
    check(seen_n, s0);
    level <= hit;
    run(d, nn);
    $display("test threshold slope %0d done", slope);
  endtask
  // Pin triggers with pre, mid and post placement
  task t_pins();
    for (int i = 0; i < 3; i++) begin
      trig_pins <= transient_capture_pkg::trig_pins_t'((i == 1) ? 2'b10 : (i == 0 ? 2'b00 : 2'b10));
      prog(2'(i), {6'h0, (i == 0) ? 2'h1 : (i == 1 ? 2'h0 : 2'h2), 3'h0, (i == 0) ? 5'h02 : 5'h00}, 16'h0,
           (i == 0) ? 16'h1 : (i == 1 ? 16'h0 : 16'h2));
      wr(A_CTL, {26'h0, 2'(i), 4'h1});
      repeat (10) @(posedge pclk);
      trig_pins <= transient_capture_pkg::trig_pins_t'((i == 0) ? 2'b10 : (i == 1 ? 2'b00 : 2'b11));
      run((i == 0) ? 1 : (i == 1 ? 0 : 2), (i == 0) ? 2 : (i == 1 ? 0 : 1));
    end
    $display("test pin triggers done");
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_dsp(1'b1, 16'hfff0, 16'hff9c, 16'h0005, 4'h5, 2'h2, 5'h01, 16'h3, 2);
    t_dsp(1'b0, 16'h0010, 16'h0020, 16'hff00, 4'h9, 2'h3, 5'h04, 16'h0, 0);
    t_pins();
    report_and_stop();
  end
endmodule
`default_nettype wire
